// ===== verilog/fisr_regs.sv
/*
  Interrupt flag, interrupt mask, function address and endpoint 0
  transmit data port of the embedded function, reached over the two-wire
  serial register port. Assumes all inputs are synchronous to sys_clk and
  that endpoint status inputs are levels held by their own registers.
*/
`timescale 1ns/100ps

module fisr_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // two-wire serial register port
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out_r,
  output logic sda_oe_r,
  // hub events, one-cycle pulses
  input wire logic suspend_event,
  input wire logic port_reset_event,
  input wire logic port_enable_event,
  input wire logic set_address_event,
  input wire logic [6:0] set_address_value,
  // hub suspend state
  input wire logic suspend_active,
  // endpoint status levels
  input wire logic ep0_tx_ack,
  input wire logic ep0_rx_ack,
  input wire logic ep0_rx_overrun,
  input wire logic ep0_rx_underrun,
  input wire logic ep1_tx_ack,
  input wire logic ep1_tx_overrun,
  input wire logic ep1_tx_underrun,
  // transmit engine side of endpoint 0 buffer
  input wire logic tx_pop,
  input wire logic tx_buffer_clear,
  output logic [7:0] tx_data_r,
  output logic tx_empty_r,
  output logic tx_full_r,
  output logic tx_overrun_r,
  output logic tx_underrun_r,
  // status outputs
  output logic irq_r,
  output logic clock_stop_ok_r,
  output logic port_reset_r,
  output logic [6:0] device_addr_r,
  output logic port_enabled_r
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  fisr_txb_if txb ();

  fisr_pkg::fisr_ser_state_t state_r;
  fisr_pkg::fisr_ser_state_t state_nxt;

  logic scl_q_r;
  logic sda_q_r;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic read_mode_r;
  logic [7:0] reg_idx_r;
  logic [7:0] rd_byte;
  logic wr_strobe_r;
  logic [7:0] wr_data_r;
  logic master_ack_r;

  logic [fisr_pkg::NUM_FLAGS-1:0] flags_r;
  logic [fisr_pkg::NUM_FLAGS-1:0] mask_r;
  logic [2:0] ep_cause;
  logic wr_flags;
  logic wr_mask;
  logic wr_txdata;

  ////////////////////////////////////////////////////////////////////////
  // transmit buffer

  fisr_tx_buffer u_tx_buffer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .txb(txb)
  );

  assign txb.push = wr_txdata;
  assign txb.push_data = wr_data_r;
  assign txb.pop = tx_pop;
  // port reset empties the buffer as well
  assign txb.clear = tx_buffer_clear || port_reset_event;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      tx_data_r <= fisr_pkg::RST_BYTE;
      tx_empty_r <= 1'b1;
      tx_full_r <= 1'b0;
      tx_overrun_r <= 1'b0;
      tx_underrun_r <= 1'b0;
    end else begin
      tx_data_r <= txb.pop_data;
      tx_empty_r <= txb.empty;
      tx_full_r <= txb.full;
      tx_overrun_r <= txb.overrun;
      tx_underrun_r <= txb.underrun;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial line conditions

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_in;
      sda_q_r <= sda_in;
    end
  end

  assign scl_rise = scl_in && !scl_q_r;
  assign scl_fall = !scl_in && scl_q_r;
  assign bus_start = scl_in && scl_q_r && sda_q_r && !sda_in;
  assign bus_stop = scl_in && scl_q_r && !sda_q_r && sda_in;

  ////////////////////////////////////////////////////////////////////////
  // serial state machine

  always_comb begin
    state_nxt = state_r;
    if (bus_start) begin
      state_nxt = fisr_pkg::SER_ADDR;
    end else if (bus_stop) begin
      state_nxt = fisr_pkg::SER_IDLE;
    end else if (scl_fall) begin
      case (state_r)
        fisr_pkg::SER_ADDR: begin
          if (bit_cnt_r == fisr_pkg::SER_BITS) begin
            if (shift_r[7:1] == fisr_pkg::SER_SLAVE_ADDR) begin
              state_nxt = fisr_pkg::SER_ADDR_ACK;
            end else begin
              state_nxt = fisr_pkg::SER_IDLE;
            end
          end
        end
        fisr_pkg::SER_ADDR_ACK: begin
          if (read_mode_r) begin
            state_nxt = fisr_pkg::SER_RDATA;
          end else begin
            state_nxt = fisr_pkg::SER_REG;
          end
        end
        fisr_pkg::SER_REG: begin
          if (bit_cnt_r == fisr_pkg::SER_BITS) begin
            state_nxt = fisr_pkg::SER_REG_ACK;
          end
        end
        fisr_pkg::SER_REG_ACK: begin
          state_nxt = fisr_pkg::SER_WDATA;
        end
        fisr_pkg::SER_WDATA: begin
          if (bit_cnt_r == fisr_pkg::SER_BITS) begin
            state_nxt = fisr_pkg::SER_WDATA_ACK;
          end
        end
        fisr_pkg::SER_WDATA_ACK: begin
          state_nxt = fisr_pkg::SER_WDATA;
        end
        fisr_pkg::SER_RDATA: begin
          if (bit_cnt_r == fisr_pkg::SER_BITS) begin
            state_nxt = fisr_pkg::SER_RDATA_ACK;
          end
        end
        fisr_pkg::SER_RDATA_ACK: begin
          // a not-acknowledge from the master ends the read burst
          if (master_ack_r) begin
            state_nxt = fisr_pkg::SER_RDATA;
          end else begin
            state_nxt = fisr_pkg::SER_IDLE;
          end
        end
        default: begin
          state_nxt = fisr_pkg::SER_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_r <= fisr_pkg::SER_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // shift register and bit count
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      shift_r <= fisr_pkg::RST_BYTE;
      bit_cnt_r <= 4'h0;
      read_mode_r <= 1'b0;
      reg_idx_r <= fisr_pkg::RST_BYTE;
      master_ack_r <= 1'b0;
    end else if (bus_start) begin
      bit_cnt_r <= 4'h0;
    end else if (state_r != state_nxt) begin
      bit_cnt_r <= 4'h0;
      if (state_r == fisr_pkg::SER_ADDR) begin
        read_mode_r <= shift_r[0];
      end
      if (state_r == fisr_pkg::SER_REG) begin
        reg_idx_r <= shift_r;
      end
      if (state_nxt == fisr_pkg::SER_RDATA) begin
        shift_r <= rd_byte;
      end
    end else if (scl_rise) begin
      case (state_r)
        fisr_pkg::SER_ADDR, fisr_pkg::SER_REG, fisr_pkg::SER_WDATA: begin
          shift_r <= {shift_r[6:0], sda_in};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
        fisr_pkg::SER_RDATA: begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
        fisr_pkg::SER_RDATA_ACK: begin
          master_ack_r <= !sda_in;
        end
        default: begin
          bit_cnt_r <= bit_cnt_r;
        end
      endcase
    end else if (scl_fall && state_r == fisr_pkg::SER_RDATA) begin
      shift_r <= {shift_r[6:0], 1'b0};
    end
  end

  // open-drain line: only ever pulled low
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sda_out_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      sda_out_r <= 1'b0;
      case (state_nxt)
        fisr_pkg::SER_ADDR_ACK, fisr_pkg::SER_REG_ACK,
        fisr_pkg::SER_WDATA_ACK: begin
          sda_oe_r <= 1'b1;
        end
        fisr_pkg::SER_RDATA: begin
          if (state_r != fisr_pkg::SER_RDATA) begin
            sda_oe_r <= !rd_byte[7];
          end else if (scl_fall) begin
            sda_oe_r <= !shift_r[6];
          end
        end
        default: begin
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // one write per received data byte
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wr_strobe_r <= 1'b0;
      wr_data_r <= fisr_pkg::RST_BYTE;
    end else begin
      wr_strobe_r <= (state_r == fisr_pkg::SER_WDATA) &&
                     (state_nxt == fisr_pkg::SER_WDATA_ACK);
      wr_data_r <= shift_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register decode

  always_comb begin
    wr_flags = 1'b0;
    wr_mask = 1'b0;
    wr_txdata = 1'b0;
    if (!wr_strobe_r) begin
      wr_flags = 1'b0;
    end else if (reg_idx_r == fisr_pkg::IDX_INT_FLAGS) begin
      wr_flags = 1'b1;
    end else if (reg_idx_r == fisr_pkg::IDX_INT_MASK) begin
      wr_mask = 1'b1;
    end else if (reg_idx_r == fisr_pkg::IDX_EP0_TX_DATA) begin
      wr_txdata = 1'b1;
    end
  end

  // reserved bits and unmapped or write-only indexes read as zero
  always_comb begin
    rd_byte = 8'h00;
    if (reg_idx_r == fisr_pkg::IDX_INT_FLAGS) begin
      rd_byte = {3'h0, flags_r};
    end else if (reg_idx_r == fisr_pkg::IDX_INT_MASK) begin
      rd_byte = {3'h0, mask_r};
    end else if (reg_idx_r == fisr_pkg::IDX_FUNC_ADDR) begin
      rd_byte = {port_enabled_r, device_addr_r};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt flags

  assign ep_cause[0] = ep0_tx_ack || txb.overrun || txb.underrun;
  assign ep_cause[1] = ep0_rx_ack || ep0_rx_overrun ||
                       ep0_rx_underrun;
  assign ep_cause[2] = ep1_tx_ack || ep1_tx_overrun ||
                       ep1_tx_underrun;

  // endpoint flags mirror their causes; writes cannot touch them
  always_ff @(posedge sys_clk) begin
    if (!reset_n || port_reset_event) begin
      flags_r[2:0] <= fisr_pkg::RST_FLAGS[2:0];
    end else begin
      flags_r[2:0] <= ep_cause;
    end
  end

  // suspend flag: set wins over a same-cycle clear
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      flags_r[fisr_pkg::BIT_SUSPEND] <= 1'b0;
    end else if (suspend_event) begin
      flags_r[fisr_pkg::BIT_SUSPEND] <= 1'b1;
    end else if (port_reset_event) begin
      flags_r[fisr_pkg::BIT_SUSPEND] <= 1'b0;
    end else if (wr_flags && wr_data_r[fisr_pkg::BIT_SUSPEND]) begin
      flags_r[fisr_pkg::BIT_SUSPEND] <= 1'b0;
    end
  end

  // reset flag survives the port reset it reports
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      flags_r[fisr_pkg::BIT_PORT_RST] <= 1'b0;
    end else if (port_reset_event) begin
      flags_r[fisr_pkg::BIT_PORT_RST] <= 1'b1;
    end else if (wr_flags && wr_data_r[fisr_pkg::BIT_PORT_RST]) begin
      flags_r[fisr_pkg::BIT_PORT_RST] <= 1'b0;
    end
  end

  // masks are kept across port reset
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mask_r <= fisr_pkg::RST_MASK;
    end else if (wr_mask) begin
      mask_r <= wr_data_r[fisr_pkg::NUM_FLAGS-1:0];
    end
  end

  // a set mask bit blocks the output; polling still sees the flag
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(flags_r & ~mask_r);
    end
  end

  // clocks may stop only when suspended and the flag has been cleared
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      clock_stop_ok_r <= 1'b0;
    end else begin
      clock_stop_ok_r <= suspend_active && !suspend_event &&
                         !flags_r[fisr_pkg::BIT_SUSPEND];
    end
  end

  // port reset request to the rest of the function logic
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      port_reset_r <= 1'b0;
    end else begin
      port_reset_r <= port_reset_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // function address and port enabled

  always_ff @(posedge sys_clk) begin
    if (!reset_n || port_reset_event) begin
      device_addr_r <= fisr_pkg::RST_ADDR;
    end else if (set_address_event) begin
      device_addr_r <= set_address_value;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n || port_reset_event) begin
      port_enabled_r <= 1'b0;
    end else if (port_enable_event) begin
      port_enabled_r <= 1'b1;
    end
  end

endmodule : fisr_regs

// ===== verilog/fisr_pkg.sv
/*
  Constants shared by the function interrupt/status register block:
  register indexes, field positions, reset values and serial port codes.
  Assumes a single 40 MHz system clock and no other bus.
*/
package fisr_pkg;

  // register indexes on the two-wire serial register port
  localparam logic [7:0] IDX_INT_FLAGS = 8'h00;
  localparam logic [7:0] IDX_INT_MASK = 8'h01;
  localparam logic [7:0] IDX_FUNC_ADDR = 8'h02;
  localparam logic [7:0] IDX_EP0_TX_DATA = 8'h04;

  // flag and mask bit positions
  localparam int BIT_CTRL_TX = 0;
  localparam int BIT_CTRL_RX = 1;
  localparam int BIT_EP1_TX = 2;
  localparam int BIT_PORT_RST = 3;
  localparam int BIT_SUSPEND = 4;
  localparam int NUM_FLAGS = 5;
  localparam int BIT_PORT_EN = 7;

  // reset values
  localparam logic [4:0] RST_FLAGS = 5'h00;
  localparam logic [4:0] RST_MASK = 5'h00;
  localparam logic [6:0] RST_ADDR = 7'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // serial port slave address; value is arbitrary
  localparam logic [6:0] SER_SLAVE_ADDR = 7'h2A;
  localparam logic [3:0] SER_BITS = 4'h8;

  // endpoint 0 transmit buffer geometry
  localparam int TXB_DEPTH = 8;
  localparam int TXB_PTR_W = 3;

  typedef enum logic [8:0] {
    SER_IDLE = 9'h001,
    SER_ADDR = 9'h002,
    SER_ADDR_ACK = 9'h004,
    SER_REG = 9'h008,
    SER_REG_ACK = 9'h010,
    SER_WDATA = 9'h020,
    SER_WDATA_ACK = 9'h040,
    SER_RDATA = 9'h080,
    SER_RDATA_ACK = 9'h100
  } fisr_ser_state_t;

endpackage : fisr_pkg

// ===== verilog/fisr_txb_if.sv
/*
  Interface between the register block and the endpoint 0 transmit
  buffer. Assumes both ends run on the same system clock.
*/
`timescale 1ns/100ps

interface fisr_txb_if;
  logic push;
  logic [7:0] push_data;
  logic pop;
  logic clear;
  logic [7:0] pop_data;
  logic empty;
  logic full;
  logic overrun;
  logic underrun;

  modport regs (
    output push, push_data, pop, clear,
    input pop_data, empty, full, overrun, underrun
  );
  modport buffer (
    input push, push_data, pop, clear,
    output pop_data, empty, full, overrun, underrun
  );
endinterface : fisr_txb_if

// ===== verilog/fisr_tx_buffer.sv
/*
  Endpoint 0 transmit buffer, eight bytes deep. The microcontroller side
  pushes, the serial engine pops. Assumes synchronous active low reset.
*/
`timescale 1ns/100ps

module fisr_tx_buffer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // buffer port
  fisr_txb_if.buffer txb
);

  logic [7:0] mem [fisr_pkg::TXB_DEPTH];
  logic [fisr_pkg::TXB_PTR_W-1:0] wr_ptr_r;
  logic [fisr_pkg::TXB_PTR_W-1:0] rd_ptr_r;
  logic [fisr_pkg::TXB_PTR_W:0] count_r;
  logic do_push;
  logic do_pop;

  assign do_push = txb.push && (count_r != 4'(fisr_pkg::TXB_DEPTH));
  assign do_pop = txb.pop && (count_r != '0);

  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      mem[wr_ptr_r] <= txb.push_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n || txb.clear) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      txb.pop_data <= fisr_pkg::RST_BYTE;
    end else begin
      if (do_push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
        txb.pop_data <= mem[rd_ptr_r];
      end
      count_r <= count_r + {3'h0, do_push} - {3'h0, do_pop};
    end
  end

  // error flags stay until the buffer is cleared
  always_ff @(posedge sys_clk) begin
    if (!reset_n || txb.clear) begin
      txb.overrun <= 1'b0;
      txb.underrun <= 1'b0;
    end else begin
      if (txb.push && !do_push) begin
        txb.overrun <= 1'b1;
      end
      if (txb.pop && !do_pop) begin
        txb.underrun <= 1'b1;
      end
    end
  end

  assign txb.empty = (count_r == '0);
  assign txb.full = (count_r == 4'(fisr_pkg::TXB_DEPTH));

endmodule : fisr_tx_buffer

// ===== test/fisr_regs_chk.sv
/*
  Port-level checker for the function interrupt/status register block.
  Assumes one clock, sys_clk, and synchronous active low reset_n.
*/
`timescale 1ns/100ps

module fisr_regs_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // watched inputs
  input wire logic suspend_event,
  input wire logic port_reset_event,
  input wire logic port_enable_event,
  input wire logic set_address_event,
  input wire logic [6:0] set_address_value,
  input wire logic suspend_active,
  // watched outputs
  input wire logic sda_out_r,
  input wire logic tx_empty_r,
  input wire logic irq_r,
  input wire logic clock_stop_ok_r,
  input wire logic port_reset_r,
  input wire logic [6:0] device_addr_r,
  input wire logic port_enabled_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////
  addr_load_a: assert property (
    set_address_event && !port_reset_event |=>
    device_addr_r == $past(set_address_value))
    else $error("address not loaded");
  addr_hold_a: assert property (
    !set_address_event && !port_reset_event |=> $stable(device_addr_r))
    else $error("address changed without cause");
  addr_clear_a: assert property (
    port_reset_event && !set_address_event && !port_enable_event |=>
    device_addr_r == 7'h00 && !port_enabled_r)
    else $error("port reset kept function state");
  enable_set_a: assert property (
    port_enable_event && !port_reset_event |=> port_enabled_r)
    else $error("port enabled not set");
  enable_hold_a: assert property (
    !port_enable_event && !port_reset_event |=> $stable(port_enabled_r))
    else $error("port enabled changed alone");
  stop_block_a: assert property (
    suspend_event |=> !clock_stop_ok_r ##1 !clock_stop_ok_r)
    else $error("clock stop while flagged");
  stop_gate_a: assert property (
    clock_stop_ok_r |-> $past(suspend_active))
    else $error("clock stop without suspend");
  reset_pulse_a: assert property (
    port_reset_r == $past(port_reset_event))
    else $error("port reset pulse wrong");
  reset_vals_a: assert property (
    $rose(reset_n) |-> !irq_r && tx_empty_r && !port_enabled_r &&
    device_addr_r == 7'h00) else $error("bad reset values");
  open_drain_a: assert property (!sda_out_r)
    else $error("data line driven high");
endmodule : fisr_regs_chk

bind fisr_regs fisr_regs_chk u_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .suspend_event(suspend_event),
  .port_reset_event(port_reset_event), .port_enable_event(port_enable_event),
  .set_address_event(set_address_event),
  .set_address_value(set_address_value), .suspend_active(suspend_active),
  .sda_out_r(sda_out_r), .tx_empty_r(tx_empty_r), .irq_r(irq_r),
  .clock_stop_ok_r(clock_stop_ok_r), .port_reset_r(port_reset_r),
  .device_addr_r(device_addr_r), .port_enabled_r(port_enabled_r)
);

// ===== test/fisr_mcu_model.sv
/*
  Behavioural microcontroller on the two-wire serial register port.
  Assumes the bench resolves the data line with a pull-up.
*/
`timescale 1ns/100ps

module fisr_mcu_model (
  // clock
  input wire logic sys_clk,
  // serial wire
  input wire logic sda_line,
  output logic scl,
  output logic sda_low,
  // read result
  output logic rd_done,
  output logic [7:0] rd_byte
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    rd_done = 1'b0;
    rd_byte = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  // extra low cycle so a data change never lands beside an scl edge
  task automatic bit_io(input logic b, output logic s);
    sda_low = !b;
    tick(4);
    scl = 1'b1;
    tick(2);
    s = sda_line;
    tick(2);
    scl = 1'b0;
    tick(1);
  endtask : bit_io

  task automatic start_c();
    sda_low = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(1);
  endtask : start_c

  task automatic stop_c();
    sda_low = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(4);
  endtask : stop_c

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask : send_byte

  task automatic write_reg(input logic [7:0] idx, input logic [7:0] d,
                           input logic with_data, output logic ack);
    logic a0;
    logic a1;
    logic a2;
    start_c();
    send_byte({fisr_pkg::SER_SLAVE_ADDR, 1'b0}, a0);
    send_byte(idx, a1);
    a2 = 1'b1;
    if (with_data) begin
      send_byte(d, a2);
    end
    stop_c();
    ack = a0 & a1 & a2;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] idx, output logic ack);
    logic a;
    logic s;
    logic [7:0] v;
    write_reg(idx, 8'h00, 1'b0, ack);
    start_c();
    send_byte({fisr_pkg::SER_SLAVE_ADDR, 1'b1}, a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      v[i] = s;
    end
    // released line reads as nack and ends the burst
    bit_io(1'b1, s);
    stop_c();
    ack = ack & a;
    rd_byte = v;
    rd_done = 1'b1;
    tick(1);
    rd_done = 1'b0;
  endtask : read_reg
endmodule : fisr_mcu_model

// ===== test/fisr_regs_test.sv
/*
  Self-checking bench for the register block with a serial master model.
  Assumes the checker is bound to the design by its own file.
*/
`timescale 1ns/100ps

module fisr_regs_test;
  logic sys_clk, reset_n, scl, sda_low, rd_done, suspend_active, nak;
  logic sda_out_r, sda_oe_r, tx_pop, tx_buffer_clear;
  logic tx_empty_r, tx_full_r, tx_overrun_r, tx_underrun_r;
  logic irq_r, clock_stop_ok_r, port_reset_r, port_enabled_r;
  logic [7:0] rd_byte, tx_data_r, d0, d1, fl;
  logic [6:0] device_addr_r, addr, cause;
  logic [3:0] ev;
  logic [31:0] rnd;
  logic [7:0] exp_q[$];
  int errors, n_compared, cycles;
  wire sda_in = !(sda_oe_r || sda_low);

  fisr_mcu_model mst (.sys_clk(sys_clk), .sda_line(sda_in), .scl(scl),
    .sda_low(sda_low), .rd_done(rd_done), .rd_byte(rd_byte));

  fisr_regs dut (.sys_clk(sys_clk), .reset_n(reset_n), .scl_in(scl),
    .sda_in(sda_in), .sda_out_r(sda_out_r), .sda_oe_r(sda_oe_r),
    .suspend_event(ev[0]), .port_reset_event(ev[1]),
    .port_enable_event(ev[2]), .set_address_event(ev[3]),
    .set_address_value(addr), .suspend_active(suspend_active),
    .ep0_tx_ack(cause[0]), .ep0_rx_ack(cause[1]),
    .ep0_rx_overrun(cause[2]), .ep0_rx_underrun(cause[3]),
    .ep1_tx_ack(cause[4]), .ep1_tx_overrun(cause[5]),
    .ep1_tx_underrun(cause[6]), .tx_pop(tx_pop),
    .tx_buffer_clear(tx_buffer_clear), .tx_data_r(tx_data_r),
    .tx_empty_r(tx_empty_r), .tx_full_r(tx_full_r),
    .tx_overrun_r(tx_overrun_r), .tx_underrun_r(tx_underrun_r),
    .irq_r(irq_r), .clock_stop_ok_r(clock_stop_ok_r),
    .port_reset_r(port_reset_r), .device_addr_r(device_addr_r),
    .port_enabled_r(port_enabled_r));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic a;
    mst.write_reg(idx, d, 1'b1, a);
    chk({7'h00, a}, 8'h01);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    logic a;
    exp_q.push_back(e);
    mst.read_reg(idx, a);
    chk({7'h00, a}, 8'h01);
  endtask : rd

  task automatic fire(input logic [3:0] e);
    ev = e;
    step(1);
    ev = 4'h0;
    step(2);
  endtask : fire

  task automatic pop_clr(input logic pop, input logic clr);
    tx_pop = pop;
    tx_buffer_clear = clr;
    step(1);
    tx_pop = 1'b0;
    tx_buffer_clear = 1'b0;
    step(2);
  endtask : pop_clr

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = !sys_clk;
  end

  always @(posedge sys_clk) begin
    if (rd_done === 1'b1) begin
      chk(rd_byte, exp_q.pop_front());
    end
  end

  // ceiling well above the roughly 22k cycles the sequence needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      $display("unexpected at %0t: run too long", $time);
      wrap_up();
    end
  end

  initial begin
    reset_n = 1'b0;
    ev = 4'h0;
    cause = 7'h00;
    addr = 7'h00;
    suspend_active = 1'b0;
    tx_pop = 1'b0;
    tx_buffer_clear = 1'b0;
    rnd = 32'h143BFE54;
    step(8);
    reset_n = 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(i[7:0], 8'h00);
    end
    chk({7'h00, irq_r}, 8'h00);
    // a foreign slave address must get no acknowledge
    mst.start_c();
    mst.send_byte({fisr_pkg::SER_SLAVE_ADDR ^ 7'h01, 1'b0}, nak);
    mst.stop_c();
    chk({7'h00, nak}, 8'h00);
    $display("test reset values done");
    rnd = lfsr(rnd);
    wr(fisr_pkg::IDX_INT_MASK, {3'b000, rnd[4:0]});
    rd(fisr_pkg::IDX_INT_MASK, {3'b000, rnd[4:0]});
    wr(fisr_pkg::IDX_INT_MASK, 8'h00);
    $display("test mask access done");
    suspend_active = 1'b1;
    fire(4'h1);
    rd(fisr_pkg::IDX_INT_FLAGS, 8'h10);
    chk({7'h00, irq_r}, 8'h01);
    chk({7'h00, clock_stop_ok_r}, 8'h00);
    wr(fisr_pkg::IDX_INT_FLAGS, 8'h07);
    rd(fisr_pkg::IDX_INT_FLAGS, 8'h10);
    wr(fisr_pkg::IDX_INT_FLAGS, 8'h10);
    rd(fisr_pkg::IDX_INT_FLAGS, 8'h00);
    chk({6'h00, irq_r, clock_stop_ok_r}, 8'h01);
    wr(fisr_pkg::IDX_INT_MASK, 8'h10);
    fire(4'h1);
    rd(fisr_pkg::IDX_INT_FLAGS, 8'h10);
    chk({7'h00, irq_r}, 8'h00);
    wr(fisr_pkg::IDX_INT_FLAGS, 8'h10);
    wr(fisr_pkg::IDX_INT_MASK, 8'h00);
    suspend_active = 1'b0;
    $display("test suspend flag done");
    for (int i = 0; i < 7; i++) begin
      fl = (i == 0) ? 8'h01 : (i < 4) ? 8'h02 : 8'h04;
      cause = 7'h01 << i;
      step(3);
      rd(fisr_pkg::IDX_INT_FLAGS, fl);
      chk({7'h00, irq_r}, 8'h01);
      wr(fisr_pkg::IDX_INT_FLAGS, 8'h07);
      rd(fisr_pkg::IDX_INT_FLAGS, fl);
      cause = 7'h00;
      step(3);
      rd(fisr_pkg::IDX_INT_FLAGS, 8'h00);
    end
    $display("test endpoint flags done");
    rnd = lfsr(rnd);
    addr = rnd[14:8];
    fire(4'h8);
    fire(4'h4);
    chk({port_enabled_r, device_addr_r}, {1'b1, addr});
    wr(fisr_pkg::IDX_FUNC_ADDR, 8'h00);
    rd(fisr_pkg::IDX_FUNC_ADDR, {1'b1, addr});
    wr(fisr_pkg::IDX_INT_MASK, 8'h05);
    fire(4'h1);
    fire(4'h2);
    rd(fisr_pkg::IDX_INT_FLAGS, 8'h08);
    chk({7'h00, irq_r}, 8'h01);
    rd(fisr_pkg::IDX_INT_MASK, 8'h05);
    rd(fisr_pkg::IDX_FUNC_ADDR, 8'h00);
    wr(fisr_pkg::IDX_INT_FLAGS, 8'h08);
    rd(fisr_pkg::IDX_INT_FLAGS, 8'h00);
    wr(fisr_pkg::IDX_INT_MASK, 8'h00);
    $display("test address and port reset done");
    rnd = lfsr(rnd);
    d0 = rnd[7:0];
    d1 = rnd[15:8];
    wr(fisr_pkg::IDX_EP0_TX_DATA, d0);
    wr(fisr_pkg::IDX_EP0_TX_DATA, d1);
    pop_clr(1'b1, 1'b0);
    chk(tx_data_r, d0);
    pop_clr(1'b1, 1'b0);
    chk(tx_data_r, d1);
    pop_clr(1'b1, 1'b0);
    step(1);
    chk({7'h00, tx_underrun_r}, 8'h01);
    rd(fisr_pkg::IDX_INT_FLAGS, 8'h01);
    pop_clr(1'b0, 1'b1);
    for (int i = 0; i < fisr_pkg::TXB_DEPTH + 1; i++) begin
      rnd = lfsr(rnd);
      wr(fisr_pkg::IDX_EP0_TX_DATA, rnd[7:0]);
    end
    chk({6'h00, tx_full_r, tx_overrun_r}, 8'h03);
    rd(fisr_pkg::IDX_INT_FLAGS, 8'h01);
    pop_clr(1'b0, 1'b1);
    step(1);
    chk({7'h00, tx_empty_r}, 8'h01);
    rd(fisr_pkg::IDX_INT_FLAGS, 8'h00);
    $display("test transmit data port done");
    wrap_up();
  end
endmodule : fisr_regs_test
